/* File: logic/encoder_motor_interface.sv */
// encoder decode, position latch, motor command outputs and watchdog for one axis
// assumes inputs synchronous to clock; the processor supplies commands and kicks
//
// Functional notes
// - decode quadrature up to 12 MHz count
// - single-ended or differential, four counts per cycle
// - index input zeroes the position count
// - stepper feedback also takes pulse plus direction
// - stepper mode drives step and direction
// - servo mode drives one 16-bit command
// - brushless mode drives two phase commands
// - hall inputs seed commutation phase after reset
// - general input edge captures position
// - seven inputs, three outputs, two 12-bit analogs
// - amplifier enable high only while serviced
// - watchdog trip lights axis error
// - trip holds until reset
// - signed 32-bit position count
`timescale 1ns/1ps
`include "motor_if_regs.svh"

module encoder_motor_interface #(
  parameter int unsigned WDOG_CYCLES = `WDOG_CYCLES
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire motor_if_pkg::motor_mode_t mode,
  input  wire logic                      differential,
  input  wire logic                      pulse_dir_feedback,
  input  wire logic                      index_enable,
  input  wire logic                      encoder_phase_a,
  input  wire logic                      encoder_phase_b,
  input  wire logic                      encoder_phase_a_neg,
  input  wire logic                      encoder_phase_b_neg,
  input  wire logic                      encoder_index,
  input  wire logic [2:0]                hall_in,
  input  wire logic                      commutation_ready,
  input  wire logic [`DAC_W-1:0]         servo_command,
  input  wire logic [`DAC_W-1:0]         phase_amplitude,
  input  wire logic [7:0]                phase_advance,
  input  wire logic                      step_request,
  input  wire logic                      step_direction,
  input  wire logic [`GPIN_N-1:0]        general_in,
  input  wire logic [2:0]                latch_select,
  input  wire logic                      latch_arm,
  input  wire logic [`GPOUT_N-1:0]       general_out_set,
  input  wire logic [`ADC_W-1:0]         analog_in_0,
  input  wire logic [`ADC_W-1:0]         analog_in_1,
  input  wire logic                      wdog_kick,
  output logic signed [`POS_W-1:0]       position,
  output logic signed [`POS_W-1:0]       latched_position,
  output logic                           latch_done,
  output logic [`DAC_W-1:0]              dac_a,
  output logic [`DAC_W-1:0]              dac_b,
  output logic                           step_out,
  output logic                           direction_out,
  output logic [`GPIN_N-1:0]             general_in_q,
  output logic [`GPOUT_N-1:0]            general_out,
  output logic [`ADC_W-1:0]              analog_0_q,
  output logic [`ADC_W-1:0]              analog_1_q,
  output logic [7:0]                     commutation_phase,
  output logic                           amplifier_enable_out,
  output logic                           axis_error
);
  import motor_if_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [1:0] a_s1_q, a_s2_q;
  logic       idx_s1_q, idx_s2_q, idx_old_q;
  logic [1:0] ab_old_q;
  logic [1:0] ab_now;
  logic       count_up, count_dn;
  logic       index_hit;
  // edge detectors stay blind until the pipeline holds real pin values
  logic [2:0] fill_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_s1_q   <= 2'h0;
      a_s2_q   <= 2'h0;
      idx_s1_q <= 1'b0;
      idx_s2_q <= 1'b0;
      fill_q   <= 3'h0;
    end else begin
      // differential pairs read a phase high only while its negative leg is low; a stuck-high negative leg holds the phase low
      a_s1_q   <= differential ? {encoder_phase_b & ~encoder_phase_b_neg, encoder_phase_a & ~encoder_phase_a_neg}
                               : {encoder_phase_b, encoder_phase_a};
      a_s2_q   <= a_s1_q;
      idx_s1_q <= encoder_index;
      idx_s2_q <= idx_s1_q;
      fill_q   <= {fill_q[1:0], 1'b1};
    end
  end

  assign ab_now = a_s2_q;
  assign index_hit = index_enable && idx_s2_q && !idx_old_q && fill_q[2];

  // ==========================================================
  // quadrature and pulse/direction decode
  always_comb begin
    count_up = 1'b0;
    count_dn = 1'b0;
    if (pulse_dir_feedback && mode == MODE_STEPPER) begin
      // phase a is pulse, phase b is direction
      count_up = ab_now[0] & ~ab_old_q[0] & ab_now[1];
      count_dn = ab_now[0] & ~ab_old_q[0] & ~ab_now[1];
    end else begin
      // gray step forward: 00->01->11->10; both bits changing is ignored
      unique case ({ab_old_q, ab_now})
        4'b0001, 4'b0111, 4'b1110, 4'b1000: count_up = 1'b1;
        4'b0010, 4'b1011, 4'b1101, 4'b0100: count_dn = 1'b1;
        default: ;
      endcase
    end
    if (!fill_q[2]) {count_up, count_dn} = 2'b00;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ab_old_q  <= 2'h0;
      idx_old_q <= 1'b0;
    end else begin
      ab_old_q  <= ab_now;
      idx_old_q <= idx_s2_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      position <= '0;
    end else if (index_hit) begin
      position <= '0;
    end else if (count_up) begin
      position <= position + 32'sd1;
    end else if (count_dn) begin
      position <= position - 32'sd1;
    end
  end

  // ==========================================================
  // position capture on general input edge
  logic trig_old_q;
  logic trig_now;
  assign trig_now = general_in_q[latch_select];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      general_in_q <= '0;
      trig_old_q   <= 1'b0;
      general_out  <= '0;
      analog_0_q   <= '0;
      analog_1_q   <= '0;
    end else begin
      general_in_q <= general_in;
      trig_old_q   <= trig_now;
      general_out  <= general_out_set;
      analog_0_q   <= analog_in_0;
      analog_1_q   <= analog_in_1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      latched_position <= '0;
      latch_done       <= 1'b0;
    end else if (latch_arm && trig_now && !trig_old_q && fill_q[2]) begin
      latched_position <= position;
      latch_done       <= 1'b1;
    end else if (latch_arm) begin
      latch_done <= 1'b0;
    end
  end

  // ==========================================================
  // commutation phase from hall sectors
  logic [7:0] hall_phase;
  logic       seeded_q;

  always_comb begin
    unique case (hall_in)
      3'b001:  hall_phase = 8'h00;
      3'b011:  hall_phase = 8'h2b;
      3'b010:  hall_phase = 8'h55;
      3'b110:  hall_phase = 8'h80;
      3'b100:  hall_phase = 8'haa;
      3'b101:  hall_phase = 8'hd5;
      default: hall_phase = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      commutation_phase <= 8'h00;
      seeded_q          <= 1'b0;
    end else if (!seeded_q && commutation_ready) begin
      commutation_phase <= hall_phase;
      seeded_q          <= 1'b1;
    end else if (seeded_q) begin
      commutation_phase <= hall_phase + phase_advance;
    end
  end

  // coarse sine: triangle of the phase, scaled by amplitude
  function automatic logic [`DAC_W-1:0] phase_out(input logic [7:0] ph, input logic [`DAC_W-1:0] amp);
    logic [6:0]  tri_v;
    logic [22:0] prod;
    tri_v = {1'b0, ph[6] ? ~ph[5:0] : ph[5:0]};
    prod  = {8'h00, amp[`DAC_W-1:1]} * {16'h0000, tri_v};
    return ph[7] ? `DAC_MID - prod[21:6] : `DAC_MID + prod[21:6];
  endfunction

  // ==========================================================
  // motor command outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dac_a <= `DAC_MID;
      dac_b <= `DAC_MID;
    end else if (!amplifier_enable_out) begin
      dac_a <= `DAC_MID;
      dac_b <= `DAC_MID;
    end else begin
      unique case (mode)
        MODE_SERVO: begin
          dac_a <= servo_command;
          dac_b <= `DAC_MID;
        end
        MODE_BRUSHLESS: begin
          dac_a <= phase_out(commutation_phase, phase_amplitude);
          dac_b <= phase_out(commutation_phase + 8'h55, phase_amplitude);
        end
        MODE_STEPPER: begin
          dac_a <= `DAC_MID;
          dac_b <= `DAC_MID;
        end
        default: begin
          dac_a <= `DAC_MID;
          dac_b <= `DAC_MID;
        end
      endcase
    end
  end

  logic [7:0] step_cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step_out      <= 1'b0;
      direction_out <= 1'b0;
      step_cnt_q    <= 8'h00;
    end else if (step_cnt_q != 8'h00) begin
      step_cnt_q <= step_cnt_q - 8'h01;
      step_out   <= (step_cnt_q != 8'h01);
    end else if (mode == MODE_STEPPER && step_request && amplifier_enable_out) begin
      direction_out <= step_direction;
      step_out      <= 1'b1;
      step_cnt_q    <= 8'(`STEP_HIGH_CYCLES);
    end
  end

  // ==========================================================
  // watchdog
  wdog_state_t          wd_q;
  logic [31:0]          wd_cnt_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wd_q     <= WD_POWERUP;
      wd_cnt_q <= '0;
    end else begin
      unique case (wd_q)
        WD_POWERUP: if (wdog_kick) begin
          wd_q     <= WD_RUN;
          wd_cnt_q <= '0;
        end
        WD_RUN: if (wdog_kick) begin
          wd_cnt_q <= '0;
        end else if (wd_cnt_q >= WDOG_CYCLES - 1) begin
          wd_q <= WD_TRIPPED;
        end else begin
          wd_cnt_q <= wd_cnt_q + 32'd1;
        end
        WD_TRIPPED: wd_q <= WD_TRIPPED;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      amplifier_enable_out <= 1'b0;
      axis_error           <= 1'b1;
    end else begin
      amplifier_enable_out <= (wd_q == WD_RUN) && !(wd_cnt_q >= WDOG_CYCLES - 1 && !wdog_kick);
      axis_error           <= (wd_q != WD_RUN) || (wd_cnt_q >= WDOG_CYCLES - 1 && !wdog_kick);
    end
  end

  // ==========================================================
  // checks
  a_enable_tripped: assert property (@(posedge clock) disable iff (!rst_n)
    wd_q == WD_TRIPPED |=> !amplifier_enable_out && axis_error)
    else $error("enable high after trip");
  a_trip_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    wd_q == WD_TRIPPED |=> wd_q == WD_TRIPPED)
    else $error("trip left without reset");
  a_enable_kicked: assert property (@(posedge clock) disable iff (!rst_n)
    amplifier_enable_out |-> $past(wd_q) != WD_POWERUP || wd_q == WD_RUN)
    else $error("enable without service");
  a_count_up_step: assert property (@(posedge clock) disable iff (!rst_n)
    count_up && !index_hit |=> position == $past(position) + 32'sd1)
    else $error("count up lost");
  a_count_dn_step: assert property (@(posedge clock) disable iff (!rst_n)
    count_dn && !index_hit |=> position == $past(position) - 32'sd1)
    else $error("count down lost");
  a_illegal_none: assert property (@(posedge clock) disable iff (!rst_n)
    !(pulse_dir_feedback && mode == MODE_STEPPER) && ab_old_q == ~ab_now |-> !count_up && !count_dn)
    else $error("illegal transition counted");
  a_index_zero: assert property (@(posedge clock) disable iff (!rst_n)
    index_hit |=> position == 32'sd0)
    else $error("index did not zero");
  a_latch_capture: assert property (@(posedge clock) disable iff (!rst_n)
    latch_arm && trig_now && !trig_old_q && fill_q[2] |=> latch_done && latched_position == $past(position))
    else $error("capture missed");
  a_servo_command: assert property (@(posedge clock) disable iff (!rst_n)
    mode == MODE_SERVO && amplifier_enable_out |=> dac_a == $past(servo_command))
    else $error("servo command not driven");
  a_hall_seed: assert property (@(posedge clock) disable iff (!rst_n)
    !seeded_q && commutation_ready |=> commutation_phase == $past(hall_phase))
    else $error("hall seed wrong");

endmodule  // encoder_motor_interface

/* File: logic/motor_if_pkg.sv */
// types shared by the motor interface
package motor_if_pkg;
  typedef enum logic [2:0] {
    MODE_SERVO     = 3'b001,
    MODE_BRUSHLESS = 3'b010,
    MODE_STEPPER   = 3'b100
  } motor_mode_t;
  typedef enum logic [2:0] {
    WD_POWERUP = 3'b001,
    WD_RUN     = 3'b010,
    WD_TRIPPED = 3'b100
  } wdog_state_t;
endpackage

/* File: logic/motor_if_regs.svh */
// constants of the motor interface: clock rates, widths, timing counts
// assumes a 50 MHz system clock
`ifndef MOTOR_IF_REGS_SVH
`define MOTOR_IF_REGS_SVH
`define CLK_MHZ          50
`define MAX_COUNT_MHZ    12
`define POS_W            32
`define DAC_W            16
`define ADC_W            12
`define GPIN_N           7
`define GPOUT_N          3
`define WDOG_TIMEOUT_US  1000
`define WDOG_CYCLES      (`WDOG_TIMEOUT_US * `CLK_MHZ)
`define STEP_HIGH_NS     1000
`define STEP_HIGH_CYCLES ((`STEP_HIGH_NS * `CLK_MHZ + 999) / 1000)
`define DAC_MID          16'h8000
`endif

/* File: tb/encoder_model.sv */
// encoder model: quadrature, pulse/direction and index lines toward the axis
// assumes the bench calls its tasks; lines change just after a falling edge
`timescale 1ns/1ps
module encoder_model (
  input  wire logic clock,
  output logic      phase_a,
  output logic      phase_b,
  output logic      phase_a_neg,
  output logic      phase_b_neg,
  output logic      index_out
);
  logic       stuck;
  logic [1:0] state;
  initial begin
    {phase_a, phase_b, index_out, stuck, state} = '0;
  end
  // complement legs follow the true legs unless forced high
  assign phase_a_neg = stuck | ~phase_a;
  assign phase_b_neg = stuck | ~phase_b;
  task automatic set_stuck(input logic s);
    stuck = s;
  endtask
  // up means phase a leads; jump moves both lines at once
  task automatic move(input logic up, input int n, input logic jump);
    repeat (n) begin
      @(negedge clock);
      state = jump ? state + 2'h2 : (up ? state + 2'h1 : state - 2'h1);
      phase_a = state[0] ^ state[1];
      phase_b = state[1];
      repeat (4) @(negedge clock); // five cycles a state: 10 MHz count rate
    end
  endtask
  task automatic pulse(input logic dir, input int n);
    repeat (n) begin
      @(negedge clock);
      phase_b = dir;
      repeat (2) @(negedge clock);
      phase_a = 1'b1;
      repeat (4) @(negedge clock);
      phase_a = 1'b0;
      repeat (4) @(negedge clock); // pulse rate well under the count limit
    end
    phase_b = state[1];
  endtask
  task automatic mark;
    @(negedge clock);
    index_out = 1'b1;
    repeat (4) @(negedge clock);
    index_out = 1'b0;
  endtask
endmodule // encoder_model

/* File: tb/testbench.sv */
// bench for the motor interface: table of encoder moves, then hand tests
// assumes the encoder model on the phase lines; inputs change at falling edges
`timescale 1ns/1ps
`include "motor_if_regs.svh"
module testbench;
  import motor_if_pkg::*;
  typedef struct packed {logic diff; logic stuck; logic up; logic [7:0] n; logic [31:0] delta;} row_t;
  row_t rows [5] = '{'{1'h0, 1'h0, 1'h1, 8'h08, 32'h8}, '{1'h0, 1'h0, 1'h0, 8'h04, 32'hfffffffc},
    '{1'h1, 1'h0, 1'h1, 8'h0c, 32'hc}, '{1'h1, 1'h1, 1'h1, 8'h08, 32'h0}, '{1'h0, 1'h0, 1'h0, 8'h06, 32'hfffffffa}};
  logic clock, rst_n, differential, pulse_dir_feedback, index_enable, encoder_index, commutation_ready;
  logic step_request, step_direction, latch_arm, kick_on, step_out, direction_out, latch_done;
  logic                     wdog_kick = 1'b0;
  logic amplifier_enable_out, axis_error, encoder_phase_a, encoder_phase_b, encoder_phase_a_neg, encoder_phase_b_neg;
  motor_mode_t              mode;
  logic [2:0]               hall_in, latch_select, general_out_set, general_out;
  logic [2:0]               kick_cnt = 3'h0;
  logic [7:0]               phase_advance, commutation_phase, ph1;
  logic [`DAC_W-1:0]        servo_command, phase_amplitude, dac_a, dac_b;
  logic [`GPIN_N-1:0]       general_in, general_in_q;
  logic [`ADC_W-1:0]        analog_in_0, analog_in_1, analog_0_q, analog_1_q;
  logic signed [`POS_W-1:0] position, latched_position, start;
  int                       err_count = 0, checks = 0, n;
  encoder_motor_interface #(.WDOG_CYCLES(20)) uut (.clock, .rst_n, .mode, .differential, .pulse_dir_feedback,
    .index_enable, .encoder_phase_a, .encoder_phase_b, .encoder_phase_a_neg, .encoder_phase_b_neg, .encoder_index,
    .hall_in, .commutation_ready, .servo_command, .phase_amplitude, .phase_advance, .step_request, .step_direction,
    .general_in, .latch_select, .latch_arm, .general_out_set, .analog_in_0, .analog_in_1, .wdog_kick, .position,
    .latched_position, .latch_done, .dac_a, .dac_b, .step_out, .direction_out, .general_in_q, .general_out,
    .analog_0_q, .analog_1_q, .commutation_phase, .amplifier_enable_out, .axis_error);
  encoder_model enc (.clock, .phase_a(encoder_phase_a), .phase_b(encoder_phase_b),
    .phase_a_neg(encoder_phase_a_neg), .phase_b_neg(encoder_phase_b_neg), .index_out(encoder_index));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  // ==========================================
  // clock, kicks, watchdog
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(negedge clock) begin
    kick_cnt <= kick_cnt + 3'h1;
    wdog_kick <= kick_on && kick_cnt == 3'h0;
  end
  initial begin
    cyc(20000);
    err_count++;
    close_out;
  end
  // ==========================================
  // tests
  initial begin
    {rst_n, differential, pulse_dir_feedback, index_enable, commutation_ready} = '0;
    {step_request, step_direction, latch_arm, kick_on, general_out_set, phase_advance} = '0;
    {general_in, analog_in_0, analog_in_1, phase_amplitude} = '0;
    mode = MODE_SERVO;
    hall_in = 3'h3; // halls only stepped between runs, far slower than one cycle per 6 ms
    latch_select = 3'h6;
    servo_command = 16'h1234;
    cyc(10);
    check(position, 32'h0);
    check(dac_a, 32'h8000);
    check(amplifier_enable_out, 32'h0);
    check(axis_error, 32'h1);
    cyc(10);
    rst_n = 1'b1;
    cyc(5);
    check(amplifier_enable_out, 32'h0);
    kick_on = 1'b1;
    cyc(12);
    check(amplifier_enable_out, 32'h1);
    check(axis_error, 32'h0);
    check(dac_a, 32'h1234);
    foreach (rows[i]) begin
      differential = rows[i].diff;
      enc.set_stuck(rows[i].stuck);
      cyc(6);
      start = position;
      enc.move(rows[i].up, rows[i].n, 1'b0);
      cyc(6);
      check(position - start, rows[i].delta);
    end
    start = position;
    enc.move(1'b1, 1, 1'b1);
    cyc(6);
    check(position - start, 32'h0);
    index_enable = 1'b1;
    enc.mark();
    cyc(6);
    check(position, 32'h0);
    index_enable = 1'b0;
    enc.move(1'b1, 3, 1'b0);
    enc.mark();
    cyc(6);
    check(position, 32'h3);
    mode = MODE_STEPPER;
    pulse_dir_feedback = 1'b1;
    enc.pulse(1'b1, 5);
    enc.pulse(1'b0, 2);
    cyc(6);
    check(position, 32'h6);
    pulse_dir_feedback = 1'b0;
    step_direction = 1'b1;
    step_request = 1'b1;
    cyc(1);
    step_request = 1'b0;
    n = 0;
    while (step_out !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (step_out === 1'b1 && n < 99) begin
      step_request = (n == 10);
      cyc(1);
      n++;
    end
    check(n, `STEP_HIGH_CYCLES);
    check(direction_out, 32'h1);
    cyc(5);
    check(step_out, 32'h0);
    {general_out_set, analog_in_0, analog_in_1, latch_arm} = {3'h5, 12'habc, 12'h123, 1'h1};
    cyc(2);
    general_in = 7'h40;
    cyc(1);
    check(general_in_q, 32'h40);
    check({general_out, analog_0_q, analog_1_q}, {3'h5, 12'habc, 12'h123});
    cyc(1);
    check(latched_position, 32'h6);
    check(latch_done, 32'h1);
    cyc(1);
    check(latch_done, 32'h0);
    mode = MODE_SERVO;
    step_request = 1'b1;
    cyc(1);
    step_request = 1'b0;
    cyc(5);
    check(step_out, 32'h0);
    mode = MODE_BRUSHLESS;
    {phase_amplitude, commutation_ready} = {16'h4000, 1'h1};
    cyc(4);
    check(dac_a !== dac_b, 32'h1);
    ph1 = commutation_phase;
    mode = MODE_SERVO;
    kick_on = 1'b0;
    cyc(30);
    check(amplifier_enable_out, 32'h0);
    check(axis_error, 32'h1);
    check(dac_a, 32'h8000);
    kick_on = 1'b1;
    cyc(20);
    check(amplifier_enable_out, 32'h0);
    {rst_n, commutation_ready, hall_in} = {1'h0, 1'h0, 3'h6};
    cyc(2);
    check(position, 32'h0);
    rst_n = 1'b1;
    cyc(12);
    check(amplifier_enable_out, 32'h1);
    check(position, 32'h0);
    mode = MODE_BRUSHLESS;
    commutation_ready = 1'b1;
    cyc(4);
    check(commutation_phase !== ph1, 32'h1);
    close_out;
  end
endmodule // testbench
